// ### rtl/erf_top.sv
// Contract
// - auto flow control turns on at full watermark, off at empty watermark
// - manual flow sends pause with timer value, repeats every 128*timer/2 tx clocks
// - clearing manual flow sends one pause frame with zero timer value
// - tx clock for pause timing is 2.5 MHz at 10 Mbps, 25 MHz at 100 Mbps
// - decrement bit reads zero; writing one lowers buffer count, zero does nothing
// - simultaneous increment and decrement leave buffer count unchanged
// - bad-crc collection accepts only packets with invalid crc
// - good-crc filtering accepts only packets with valid crc
// - short collection accepts only packets under 64 bytes, valid crc if required
// - short rejection discards packets under 64 bytes
// - unicast filter accepts unicast addressed to the station address
// - other-unicast filter accepts unicast not addressed to the station address
// - multicast filter accepts every multicast destination except broadcast
// - broadcast filter accepts every broadcast destination
// - hash match counts regardless of hash filter enable
// - magic match counts regardless of magic filter enable
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "erf_regs.svh"
module erf_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_WIDTH = 32
) (
  input  wire logic        i_sys_clk,          // system clock, 40 MHz
  input  wire logic        i_sys_rst,          // sync reset, active high
  input  wire logic [7:0]  i_addr,             // register byte address
  input  wire logic [31:0] i_wdata,            // register write data
  input  wire logic        i_wr,               // write strobe
  input  wire logic        i_rd,               // read strobe
  output logic [31:0]      o_rdata,            // read data, cycle after strobe
  input  wire logic        i_rx_buf_inc,       // receive logic adds a buffer
  output logic [7:0]       o_rx_buffer_count,  // received buffer count
  output logic             o_flow_active,      // flow control announced on
  output logic             o_pause_valid,      // pause frame request
  input  wire logic        i_pause_ready,      // transmitter takes pause frame
  output logic [15:0]      o_pause_timer,      // pause timer value of frame
  input  wire logic        i_pkt_valid,        // packet verdict request
  output logic             o_pkt_ready,        // filter can take a packet
  input  wire logic        i_pkt_crc_ok,       // packet crc valid
  input  wire logic [15:0] i_pkt_len,          // packet length in bytes
  input  wire logic [47:0] i_pkt_dest,         // destination address
  input  wire logic        i_hash_match,       // hash table filter hit
  input  wire logic        i_magic_match,      // magic packet filter hit
  output logic             o_acc_valid,        // accepted packet descriptor valid
  input  wire logic        i_acc_ready,        // descriptor consumer ready
  output logic [31:0]      o_acc_data,         // accepted packet descriptor
  output logic             o_module_on,        // controller on
  output logic             o_receive_enable,   // receive enable
  output logic             o_hash_filter_en,   // hash filter enable
  output logic             o_magic_filter_en   // magic filter enable
);

  erf_pkg::erf_state_t s;
  erf_pkg::erf_state_t n;

  logic        wr_ctrl;
  logic        dec_req;
  logic        flow_on;
  logic [17:0] acc_sum;
  logic        tx_tick;
  logic [21:0] period_load;
  logic        is_group;
  logic        is_bcast;
  logic        is_me;
  logic        is_runt;
  logic        hit_uc;
  logic        hit_notme;
  logic        hit_mc;
  logic        hit_bc;
  logic        any_hit;
  logic        mand_ok;
  logic        accept;
  logic        take;
  logic        push;
  logic        fifo_in_ready;
  logic [31:0] push_data;

  // register-write decode for the decrement strobe
  assign wr_ctrl = i_wr && (i_addr == `ERF_OFS_CTRL);
  assign dec_req = wr_ctrl && i_wdata[`ERF_CTRL_BUFDEC];

  // flow request is manual or watermark driven
  assign flow_on = s.man_fc || s.auto_active;

  // tx clock rate from link speed, fractional accumulator
  assign acc_sum = {1'b0, s.tick_acc} + (s.spd100 ? 18'(`ERF_TXCLK_100M_KHZ)
                                                  : 18'(`ERF_TXCLK_10M_KHZ));
  assign tx_tick = (acc_sum >= 18'(`ERF_SYSCLK_KHZ));
  assign period_load = (s.pause_timer_value == `ERF_PTV_ZERO) ? 22'h000001
                     : 22'(s.pause_timer_value) * 22'(`ERF_PAUSE_MULT / `ERF_PAUSE_DIV);

  // address classification
  assign is_group  = i_pkt_dest[`ERF_GROUP_BIT];
  assign is_bcast  = (i_pkt_dest == `ERF_BCAST_ADDR);
  assign is_me     = (i_pkt_dest == s.sta);
  assign is_runt   = (i_pkt_len < 16'(`ERF_RUNT_BYTES));
  assign hit_uc    = s.rxfc[`ERF_RXFC_UCAST] && !is_group && is_me;
  assign hit_notme = s.rxfc[`ERF_RXFC_NOTME] && !is_group && !is_me;
  assign hit_mc    = s.rxfc[`ERF_RXFC_MCAST] && is_group && !is_bcast;
  assign hit_bc    = s.rxfc[`ERF_RXFC_BCAST] && is_bcast;
  // hash and magic matches count without their enables
  assign any_hit   = hit_uc || hit_notme || hit_mc || hit_bc || i_hash_match || i_magic_match;

  // mandatory checks: crc and length filters
  assign mand_ok = !(s.rxfc[`ERF_RXFC_CRCERR] && i_pkt_crc_ok)
                && !(s.rxfc[`ERF_RXFC_CRCOK] && !i_pkt_crc_ok)
                && !(s.rxfc[`ERF_RXFC_RUNTCOL] && !is_runt)
                && !(s.rxfc[`ERF_RXFC_RUNTREJ] && is_runt);
  assign accept  = mand_ok && any_hit;

  // verdict handshake, stalled by the descriptor fifo
  assign o_pkt_ready = s.on && s.rx_en && fifo_in_ready;
  assign take        = i_pkt_valid && o_pkt_ready;
  assign push        = take && accept;
  assign push_data   = {8'h00, i_magic_match, i_hash_match, hit_bc, hit_mc, hit_notme, hit_uc,
                        is_runt, i_pkt_crc_ok, i_pkt_len};

  // next-state logic: registers, buffer count, flow control, pause frames
  always_comb begin
    n = s;
    n.rdata = '0;
    // register writes
    if (i_wr) begin
      case (i_addr)
        `ERF_OFS_CTRL: begin
          n.on      = i_wdata[`ERF_CTRL_ON];
          n.rx_en   = i_wdata[`ERF_CTRL_RECEIVE_ENABLE];
          n.auto_fc = i_wdata[`ERF_CTRL_AUTO_FLOW_CTL_EN];
          n.man_fc  = i_wdata[`ERF_CTRL_MANUAL_FLOW_CTL_EN];
          n.spd100  = i_wdata[`ERF_CTRL_SPD100];
        end
        `ERF_OFS_RXFC:   n.rxfc = i_wdata[9:0];
        `ERF_OFS_PTV:    n.pause_timer_value = i_wdata[15:0];
        `ERF_OFS_WMARK: begin
          n.wm_full  = i_wdata[`ERF_WM_FULL_LSB +: 8];
          n.wm_empty = i_wdata[`ERF_WM_EMPTY_LSB +: 8];
        end
        `ERF_OFS_STA_LO: n.sta[31:0] = i_wdata;
        `ERF_OFS_STA_HI: n.sta[47:32] = i_wdata[15:0];
        default: ;
      endcase
    end
    // register reads, data in the following cycle
    if (i_rd) begin
      case (i_addr)
        `ERF_OFS_CTRL: begin
          n.rdata[`ERF_CTRL_ON]     = s.on;
          n.rdata[`ERF_CTRL_RECEIVE_ENABLE]   = s.rx_en;
          n.rdata[`ERF_CTRL_AUTO_FLOW_CTL_EN] = s.auto_fc;
          n.rdata[`ERF_CTRL_MANUAL_FLOW_CTL_EN]  = s.man_fc;
          n.rdata[`ERF_CTRL_SPD100] = s.spd100;
        end
        `ERF_OFS_RXFC:   n.rdata[9:0] = s.rxfc;
        `ERF_OFS_PTV:    n.rdata[15:0] = s.pause_timer_value;
        `ERF_OFS_WMARK: begin
          n.rdata[`ERF_WM_FULL_LSB +: 8]  = s.wm_full;
          n.rdata[`ERF_WM_EMPTY_LSB +: 8] = s.wm_empty;
        end
        `ERF_OFS_STAT: begin
          n.rdata[`ERF_STAT_FLOW]       = s.flow_sent;
          n.rdata[`ERF_STAT_PBUSY]      = (s.pst == erf_pkg::ERF_PS_SEND);
          n.rdata[`ERF_STAT_CNT_LSB +: 8] = s.buf_cnt;
        end
        `ERF_OFS_STA_LO: n.rdata = s.sta[31:0];
        `ERF_OFS_STA_HI: n.rdata[15:0] = s.sta[47:32];
        default: ;
      endcase
    end
    // buffer count, both at once cancel
    case ({i_rx_buf_inc, dec_req})
      2'b10:   n.buf_cnt = (s.buf_cnt == 8'hFF) ? s.buf_cnt : s.buf_cnt + 8'h01;
      2'b01:   n.buf_cnt = (s.buf_cnt == 8'h00) ? s.buf_cnt : s.buf_cnt - 8'h01;
      default: n.buf_cnt = s.buf_cnt;
    endcase
    // watermark flow control
    if (!s.auto_fc) begin
      n.auto_active = 1'b0;
    end else if (s.buf_cnt >= s.wm_full) begin
      n.auto_active = 1'b1;
    end else if (s.buf_cnt <= s.wm_empty) begin
      n.auto_active = 1'b0;
    end
    // tx clock tick accumulator
    n.tick_acc = tx_tick ? 17'(acc_sum - 18'(`ERF_SYSCLK_KHZ)) : acc_sum[16:0];
    // pause frame sequencer
    case (s.pst)
      erf_pkg::ERF_PS_IDLE: begin
        if (flow_on != s.flow_sent) begin
          n.flow_sent = flow_on;
          n.pause_val = flow_on ? s.pause_timer_value : `ERF_PTV_ZERO;
          n.pst       = erf_pkg::ERF_PS_SEND;
        end
      end
      erf_pkg::ERF_PS_SEND: begin
        if (i_pause_ready) begin
          if (s.flow_sent) begin
            n.period_cnt = period_load;
            n.pst        = erf_pkg::ERF_PS_WAIT;
          end else begin
            n.pst = erf_pkg::ERF_PS_IDLE;
          end
        end
      end
      erf_pkg::ERF_PS_WAIT: begin
        if (!flow_on) begin
          n.pst = erf_pkg::ERF_PS_IDLE;
        end else if (tx_tick) begin
          if (s.period_cnt <= 22'h000001) begin
            n.pause_val = s.pause_timer_value;
            n.pst       = erf_pkg::ERF_PS_SEND;
          end else begin
            n.period_cnt = s.period_cnt - 22'h000001;
          end
        end
      end
      default: n.pst = erf_pkg::ERF_PS_IDLE;
    endcase
  end

  // state register, all fields clear at reset
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // accepted packet descriptors
  erf_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_acc_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (FIFO_WIDTH'(push_data)),
    .o_out_valid (o_acc_valid),
    .i_out_ready (i_acc_ready),
    .o_out_data  (o_acc_data)
  );

  // outputs from the state register
  assign o_rdata           = s.rdata;
  assign o_rx_buffer_count = s.buf_cnt;
  assign o_flow_active     = s.flow_sent;
  assign o_pause_valid     = (s.pst == erf_pkg::ERF_PS_SEND);
  assign o_pause_timer     = s.pause_val;
  assign o_module_on       = s.on;
  assign o_receive_enable  = s.rx_en;
  assign o_hash_filter_en  = s.rxfc[`ERF_RXFC_HASH];
  assign o_magic_filter_en = s.rxfc[`ERF_RXFC_MAGIC];

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  chk_auto_flow_on: assert property (
    s.auto_fc && (s.buf_cnt >= s.wm_full) |=> s.auto_active)
    else $error("auto flow not on at full watermark");
  chk_auto_flow_off: assert property (
    s.auto_fc && (s.buf_cnt <= s.wm_empty) && (s.buf_cnt < s.wm_full) |=> !s.auto_active)
    else $error("auto flow not off at empty watermark");
  chk_pause_repeat: assert property (
    (s.pst == erf_pkg::ERF_PS_WAIT) && flow_on && tx_tick && (s.period_cnt == 22'h000001)
    |=> o_pause_valid && (o_pause_timer == $past(s.pause_timer_value)))
    else $error("pause frame not repeated with timer value");
  chk_period_load: assert property (
    o_pause_valid && i_pause_ready && s.flow_sent
    |=> s.period_cnt == (($past(s.pause_timer_value) == `ERF_PTV_ZERO) ? 22'h000001
                        : 22'($past(s.pause_timer_value)) * 22'(`ERF_PAUSE_MULT / `ERF_PAUSE_DIV)))
    else $error("pause period wrong");
  chk_zero_frame: assert property (
    (s.pst == erf_pkg::ERF_PS_IDLE) && s.flow_sent && !flow_on
    |=> o_pause_valid && (o_pause_timer == `ERF_PTV_ZERO))
    else $error("zero pause frame missing");
  chk_tick_fast: assert property (
    s.spd100 && !tx_tick |=> tx_tick || !s.spd100)
    else $error("100M tx clock too slow");
  chk_tick_slow: assert property (
    !s.spd100 && tx_tick |=> (!tx_tick || s.spd100) [*8])
    else $error("10M tx clock too fast");
  chk_dec_count: assert property (
    dec_req && !i_rx_buf_inc && (s.buf_cnt != 8'h00) |=> s.buf_cnt == $past(s.buf_cnt) - 8'h01)
    else $error("decrement did not lower count");
  chk_dec_reads_zero: assert property (
    i_rd && (i_addr == `ERF_OFS_CTRL) |=> !o_rdata[`ERF_CTRL_BUFDEC])
    else $error("decrement bit read as one");
  chk_inc_dec_hold: assert property (
    i_rx_buf_inc && dec_req |=> $stable(s.buf_cnt))
    else $error("count moved on inc and dec");
  chk_bad_crc_only: assert property (
    take && s.rxfc[`ERF_RXFC_CRCERR] && i_pkt_crc_ok |-> !push)
    else $error("good crc taken in bad-crc mode");
  chk_good_crc_only: assert property (
    take && s.rxfc[`ERF_RXFC_CRCOK] && !i_pkt_crc_ok |-> !push)
    else $error("bad crc accepted");
  chk_short_collect: assert property (
    take && s.rxfc[`ERF_RXFC_RUNTCOL] && !is_runt |-> !push)
    else $error("long packet taken in short collection");
  chk_short_reject: assert property (
    take && s.rxfc[`ERF_RXFC_RUNTREJ] && is_runt |-> !push)
    else $error("short packet accepted");
  chk_ucast_accept: assert property (
    take && mand_ok && s.rxfc[`ERF_RXFC_UCAST] && !is_group && is_me |-> push)
    else $error("own unicast dropped");
  chk_notme_accept: assert property (
    take && mand_ok && s.rxfc[`ERF_RXFC_NOTME] && !is_group && !is_me |-> push)
    else $error("other unicast dropped");
  chk_mcast_accept: assert property (
    take && mand_ok && s.rxfc[`ERF_RXFC_MCAST] && is_group && !is_bcast |-> push)
    else $error("multicast dropped");
  chk_bcast_accept: assert property (
    take && mand_ok && s.rxfc[`ERF_RXFC_BCAST] && is_bcast |-> push)
    else $error("broadcast dropped");
  chk_hash_always: assert property (
    take && mand_ok && i_hash_match |-> push)
    else $error("hash match ignored");
  chk_magic_always: assert property (
    take && mand_ok && i_magic_match |-> push)
    else $error("magic match ignored");
  chk_accept_rule: assert property (
    push |-> mand_ok && any_hit && s.rx_en)
    else $error("packet accepted without cause");

  cov_manual_pause: cover property (s.man_fc && o_pause_valid && i_pause_ready ##1 s.pst == erf_pkg::ERF_PS_WAIT);
  cov_zero_pause: cover property (o_pause_valid && (o_pause_timer == `ERF_PTV_ZERO) && i_pause_ready);
  cov_fifo_stall: cover property (i_pkt_valid && s.rx_en && s.on && !fifo_in_ready);
  cov_inc_dec: cover property (i_rx_buf_inc && dec_req);

endmodule

// ### rtl/erf_regs.svh
`ifndef ERF_REGS_SVH
`define ERF_REGS_SVH

// register byte offsets
`define ERF_OFS_CTRL       8'h00
`define ERF_OFS_RXFC       8'h04
`define ERF_OFS_PTV        8'h08
`define ERF_OFS_WMARK      8'h0C
`define ERF_OFS_STAT       8'h10
`define ERF_OFS_STA_LO     8'h14
`define ERF_OFS_STA_HI     8'h18

// controller_control_one fields
`define ERF_CTRL_BUFDEC    0
`define ERF_CTRL_MANUAL_FLOW_CTL_EN     4
`define ERF_CTRL_AUTO_FLOW_CTL_EN    7
`define ERF_CTRL_RECEIVE_ENABLE      8
`define ERF_CTRL_SPD100    9
`define ERF_CTRL_ON        15

// receive_filter_config fields
`define ERF_RXFC_BCAST     0
`define ERF_RXFC_MCAST     1
`define ERF_RXFC_NOTME     2
`define ERF_RXFC_UCAST     3
`define ERF_RXFC_RUNTREJ   4
`define ERF_RXFC_RUNTCOL   5
`define ERF_RXFC_CRCOK     6
`define ERF_RXFC_CRCERR    7
`define ERF_RXFC_HASH      8
`define ERF_RXFC_MAGIC     9

// watermark and status fields
`define ERF_WM_FULL_LSB    0
`define ERF_WM_EMPTY_LSB   8
`define ERF_STAT_FLOW      0
`define ERF_STAT_PBUSY     1
`define ERF_STAT_CNT_LSB   16

// packet and address figures
`define ERF_RUNT_BYTES     64
`define ERF_GROUP_BIT      40
`define ERF_BCAST_ADDR     48'hFFFF_FFFF_FFFF
`define ERF_PTV_ZERO       16'h0000

// pause timing: period = 128 * timer / 2 transmit clocks
`define ERF_PAUSE_MULT     128
`define ERF_PAUSE_DIV      2
`define ERF_TXCLK_10M_KHZ  2500
`define ERF_TXCLK_100M_KHZ 25000
`define ERF_SYSCLK_KHZ     40000

`endif

// ### rtl/erf_pkg.sv
package erf_pkg;

  typedef enum logic [1:0] {
    ERF_PS_IDLE = 2'b00,
    ERF_PS_SEND = 2'b01,
    ERF_PS_WAIT = 2'b10
  } erf_pause_st_t;

  typedef struct packed {
    logic [31:0]   rdata;
    logic          on;
    logic          rx_en;
    logic          auto_fc;
    logic          man_fc;
    logic          spd100;
    logic [9:0]    rxfc;
    logic [15:0]   pause_timer_value;
    logic [7:0]    wm_full;
    logic [7:0]    wm_empty;
    logic [47:0]   sta;
    logic [7:0]    buf_cnt;
    logic          auto_active;
    logic          flow_sent;
    erf_pause_st_t pst;
    logic [15:0]   pause_val;
    logic [21:0]   period_cnt;
    logic [16:0]   tick_acc;
  } erf_state_t;

endpackage

// ### rtl/erf_fifo.sv
`timescale 1ns/10ps
module erf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             i_sys_clk,  // system clock
  input  wire logic             i_sys_rst,  // sync reset, active high
  input  wire logic             i_in_valid, // write side valid
  output logic                  o_in_ready, // write side ready
  input  wire logic [WIDTH-1:0] i_in_data,  // write data
  output logic                  o_out_valid, // read side valid
  input  wire logic             i_out_ready, // read side ready
  output logic [WIDTH-1:0]      o_out_data  // read data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } erf_fifo_st_t;

  erf_fifo_st_t fifo_reg;
  erf_fifo_st_t fifo_next;
  logic         push;
  logic         pop;

  // honest full and empty flags
  assign o_in_ready  = (fifo_reg.count != (AW+1)'(DEPTH));
  assign o_out_valid = (fifo_reg.count != '0);
  assign o_out_data  = fifo_reg.mem[fifo_reg.rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer and storage update
  always_comb begin
    fifo_next = fifo_reg;
    if (push) begin
      fifo_next.mem[fifo_reg.wr_ptr] = i_in_data;
      fifo_next.wr_ptr = (fifo_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : fifo_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      fifo_next.rd_ptr = (fifo_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : fifo_reg.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   fifo_next.count = fifo_reg.count + 1'b1;
      2'b01:   fifo_next.count = fifo_reg.count - 1'b1;
      default: fifo_next.count = fifo_reg.count;
    endcase
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

endmodule

// ### verification/erf_partner.sv
`timescale 1ns/10ps
// far side: transmitter that takes pause frames, and consumer of packet descriptors
module erf_partner (
  input  wire logic i_sys_clk,     // system clock
  input  wire logic i_sys_rst,     // sync reset, active high
  input  wire logic i_stall,       // holds the descriptor consumer off
  input  wire logic i_pause_valid, // pause frame request
  output logic      o_pause_ready, // transmitter takes the frame
  input  wire logic i_acc_valid,   // descriptor waiting
  output logic      o_acc_ready    // consumer takes a descriptor
);
  logic [1:0] wait_reg;
  logic [1:0] ph_reg;

  // transmitter is slow: two busy cycles before it takes a frame
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wait_reg <= 2'h0;
      ph_reg   <= 2'h0;
    end else begin
      wait_reg <= (i_pause_valid && !o_pause_ready) ? wait_reg + 2'h1 : 2'h0;
      ph_reg   <= ph_reg + 2'h1;
    end
  end

  // consumer skips every fourth cycle so the queue sees both prompt and slow takes
  assign o_pause_ready = (wait_reg == 2'h2);
  assign o_acc_ready   = !i_stall && (ph_reg != 2'h3);
endmodule

// ### verification/ethernet_rx_filter_flow_control_tb_top.sv
`timescale 1ns/10ps
`include "erf_regs.svh"
module ethernet_rx_filter_flow_control_tb_top;
  logic        i_sys_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_rx_buf_inc = 1'b0, i_pkt_valid = 1'b0, i_pkt_crc_ok = 1'b0;
  logic        i_hash_match = 1'b0, i_magic_match = 1'b0, stall = 1'b0, i_pause_ready, i_acc_ready;
  logic [15:0] i_pkt_len = 16'h0, o_pause_timer, len;
  logic [47:0] i_pkt_dest = 48'h0, sta = 48'h0, dst;
  logic [31:0] o_rdata, o_acc_data, ctrl, d, r;
  logic [7:0]  o_rx_buffer_count;
  logic        o_flow_active, o_pause_valid, o_pkt_ready, o_acc_valid;
  logic        o_module_on, o_receive_enable, o_hash_filter_en, o_magic_filter_en;
  logic [9:0]  fc = 10'h0;
  logic [31:0] expq[$];
  logic [15:0] pt[$];
  int          pc[$];
  int          fails = 0, samples_checked = 0, cyc = 0, cnt = 0, lo, hi, k;
  integer      seed = 32'h76f609f7;

  always #12.5 i_sys_clk = ~i_sys_clk;

  erf_top i_dut (.i_sys_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rx_buf_inc,
    .o_rx_buffer_count, .o_flow_active, .o_pause_valid, .i_pause_ready, .o_pause_timer, .i_pkt_valid,
    .o_pkt_ready, .i_pkt_crc_ok, .i_pkt_len, .i_pkt_dest, .i_hash_match, .i_magic_match, .o_acc_valid,
    .i_acc_ready, .o_acc_data, .o_module_on, .o_receive_enable, .o_hash_filter_en, .o_magic_filter_en);

  erf_partner i_far (.i_sys_clk, .i_sys_rst, .i_stall(stall), .i_pause_valid(o_pause_valid),
    .o_pause_ready(i_pause_ready), .i_acc_valid(o_acc_valid), .o_acc_ready(i_acc_ready));

  task chk(input logic [47:0] g, input logic [47:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task test_done;
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk) i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk) i_rd <= 1'b0;
    #1 v = o_rdata;
    @(posedge i_sys_clk);
  endtask

  task setc(input logic [31:0] v);
    ctrl = v;
    wr(`ERF_OFS_CTRL, v);
  endtask

  // receive logic increment and software decrement, possibly in the same cycle
  task bufop(input logic inc, input logic dec);
    i_rx_buf_inc <= inc;
    i_addr       <= `ERF_OFS_CTRL;
    i_wdata      <= ctrl | {31'h0, dec};
    i_wr         <= dec;
    @(posedge i_sys_clk) i_rx_buf_inc <= 1'b0;
    i_wr <= 1'b0;
    cnt = cnt + inc - dec;
    @(posedge i_sys_clk);
  endtask

  task waitq(input int n, input int lim);
    for (k = 0; k < lim && pt.size() < n; k++) @(posedge i_sys_clk);
    if (pt.size() < n) begin
      fails++;
      test_done;
    end
  endtask

  task drain;
    for (k = 0; k < 400 && expq.size() > 0; k++) @(posedge i_sys_clk);
    chk(expq.size(), 0);
  endtask

  function logic acc(input logic [47:0] a, input logic [15:0] n, input logic c, input logic h, input logic m);
    logic uc, ok;
    uc = !a[`ERF_GROUP_BIT];
    ok = !(fc[7] && c) && !(fc[6] && !c) && !(fc[5] && n >= `ERF_RUNT_BYTES) && !(fc[4] && n < `ERF_RUNT_BYTES);
    return ok && (h || m || (fc[3] && uc && a == sta) || (fc[2] && uc && a != sta) ||
      (fc[1] && !uc && a != `ERF_BCAST_ADDR) || (fc[0] && a == `ERF_BCAST_ADDR));
  endfunction

  // valid stays up between packets so they go back to back
  task pkt(input logic [47:0] a, input logic [15:0] n, input logic c, input logic h, input logic m);
    int w;
    i_pkt_dest <= a;
    i_pkt_len <= n;
    i_pkt_crc_ok <= c;
    i_hash_match <= h;
    i_magic_match <= m;
    i_pkt_valid <= 1'b1;
    w = 0;
    do begin
      @(negedge i_sys_clk);
      w++;
    end while (o_pkt_ready !== 1'b1 && w < 300);
    if (o_pkt_ready !== 1'b1) begin
      fails++;
      test_done;
    end
    @(posedge i_sys_clk);
    if (acc(a, n, c, h, m)) expq.push_back({8'h0, m, h, 4'h0, n < `ERF_RUNT_BYTES, c, n});
  endtask

  // descriptor and pause frame monitors
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (!i_sys_rst && o_acc_valid === 1'b1 && i_acc_ready === 1'b1)
      chk(o_acc_data & 32'hFFC3_FFFF, expq.size() ? expq.pop_front() : 48'hFFFF_FFFF_FFFF);
    if (!i_sys_rst && o_pause_valid === 1'b1 && i_pause_ready === 1'b1) begin
      pt.push_back(o_pause_timer);
      pc.push_back(cyc);
    end
  end

  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(`ERF_OFS_RXFC, d);
    chk(d, 0);
    rd(`ERF_OFS_STAT, d);
    chk(d, 0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, d);
    chk(d, 0);
    // buffer count
    setc(32'h0000_8000);
    repeat (3) bufop(1'b1, 1'b0);
    bufop(1'b1, 1'b1);
    chk(o_rx_buffer_count, cnt);
    bufop(1'b0, 1'b1);
    wr(`ERF_OFS_CTRL, ctrl);
    rd(`ERF_OFS_CTRL, d);
    chk(d & 32'h0000_8391, ctrl);
    rd(`ERF_OFS_STAT, d);
    chk(d[23:16], cnt);
    repeat (2) bufop(1'b0, 1'b1);
    // automatic flow control on the watermarks
    wr(`ERF_OFS_PTV, 32'h5);
    wr(`ERF_OFS_WMARK, 32'h0000_0103);
    setc(32'h0000_8080);
    repeat (2) bufop(1'b1, 1'b0);
    repeat (20) @(posedge i_sys_clk);
    chk({pt.size(), o_flow_active}, 0);
    bufop(1'b1, 1'b0);
    waitq(1, 50);
    chk({pt[0], o_flow_active}, {16'h5, 1'b1});
    bufop(1'b0, 1'b1);
    repeat (20) @(posedge i_sys_clk);
    chk(pt.size(), 1);
    bufop(1'b0, 1'b1);
    waitq(2, 50);
    chk({pt[1], o_flow_active}, 0);
    // manual pause repetition at both link speeds
    for (int s = 0; s < 2; s++) begin
      pt.delete();
      pc.delete();
      wr(`ERF_OFS_PTV, s + 1);
      setc(s ? 32'h0000_8210 : 32'h0000_8010);
      waitq(2, 2500);
      chk({pt[0], pt[1]}, {16'(s + 1), 16'(s + 1)});
      lo = s ? 202 : 1008;
      hi = s ? 212 : 1032;
      chk(pc[1] - pc[0] >= lo && pc[1] - pc[0] <= hi, 1);
      setc(32'h0000_8000);
      waitq(3, 100);
      repeat (5) @(posedge i_sys_clk);
      chk({pt[2], o_flow_active}, 0);
    end
    // random packets against random filter settings
    sta = {$random(seed), $random(seed)} & 48'hFEFF_FFFF_FFFF;
    wr(`ERF_OFS_STA_LO, sta[31:0]);
    wr(`ERF_OFS_STA_HI, {16'h0, sta[47:32]});
    rd(`ERF_OFS_STA_HI, d);
    chk(d, {16'h0, sta[47:32]});
    repeat (41) begin
      fc = $random(seed);
      setc(0);
      wr(`ERF_OFS_RXFC, {22'h0, fc});
      setc(32'h0000_8100);
      chk({o_hash_filter_en, o_magic_filter_en, o_receive_enable, o_module_on}, {fc[8], fc[9], 2'h3});
      repeat (8) begin
        r = $random(seed);
        dst = {$random(seed), $random(seed)};
        dst[`ERF_GROUP_BIT] = r[1];
        if (r[1:0] == 2'h0) dst = sta;
        if (r[1:0] == 2'h3 && r[2]) dst = `ERF_BCAST_ADDR;
        len = r[3] ? 16'd63 + r[4] : 16'd64 + r[15:8];
        pkt(dst, len, r[5], r[7:6] == 2'h0, r[9:8] == 2'h0);
      end
      i_pkt_valid <= 1'b0;
      @(posedge i_sys_clk);
      drain;
    end
    // fill the descriptor queue until it refuses, then drain
    fc = 10'h001;
    setc(0);
    wr(`ERF_OFS_RXFC, 32'h1);
    setc(32'h0000_8100);
    stall <= 1'b1;
    repeat (16) pkt(`ERF_BCAST_ADDR, 16'd100, 1'b1, 1'b0, 1'b0);
    i_pkt_valid <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_pkt_ready, 0);
    stall = 1'b0;
    drain;
    chk(o_acc_valid, 0);
    test_done;
  end
endmodule
